// ===== test/ext_access_ctrl_asserts.sv
// Purpose: port checks for the access controller
// Assumes: one clock, synchronous active-low reset
// Notes:   mode is not visible here, so widths are bounded
`timescale 1ns/1ps
module ext_access_ctrl_asserts #(
	parameter int CFG_W = 7
) (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        rd_n_o,
	input wire logic        wr_n_o,
	input wire logic        data_strobe_n_o,
	input wire logic [3:0]  upper_local_addr_o,
	input wire logic [15:0] data_o,
	input wire logic [1:0]  data_oe_o,
	input wire logic        test_pin_a_i,
	input wire logic        test_pin_b_i,
	input wire logic        bus_ack_o,
	input wire logic        bus_avail_o
);
	// ==========
	// strobe length counter
	logic       act;
	logic [7:0] len_q;
	assign act = !(rd_n_o && wr_n_o && data_strobe_n_o);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !act) begin
			len_q <= 8'h00;
		end else begin
			len_q <= len_q + 8'h01;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence strobe_rise; $rose(act); endsequence
	sequence strobe_held; act [*8]; endsequence
	// ==========
	// properties
	strobe_one_a: assert property (
		$onehot0({!rd_n_o, !wr_n_o, !data_strobe_n_o}))
		else $error("two strobes low");
	ack_follow_a: assert property (
		bus_ack_o |-> $past(test_pin_a_i)) else $error("bad ack");
	avail_follow_a: assert property (
		bus_avail_o |-> $past(test_pin_b_i)) else $error("bad avail");
	pulse_min_a: assert property (
		strobe_rise |-> strobe_held) else $error("short strobe");
	pulse_max_a: assert property (
		len_q <= 8'h40) else $error("long strobe");
	addr_hold_a: assert property (
		act && $past(act) |-> $stable(upper_local_addr_o))
		else $error("address moved");
	wdata_hold_a: assert property (
		!wr_n_o && !$past(wr_n_o) |-> $stable(data_o))
		else $error("write data moved");
	// reset must park strobes and float the data lanes
	rst_idle_a: assert property (disable iff (1'b0)
		!rst_n_i |=> !act && data_oe_o == 2'h0)
		else $error("busy in reset");
endmodule

// ===== test/ext_access_ctrl_tb.sv
// Purpose: self-checking bench for the access controller
// Assumes: AHB-Lite single words, 200 MHz clock
// Notes:   fast reads are compared only for the zeroed upper byte: the peripheral is too slow
`timescale 1ns/1ps
module ext_access_ctrl_tb;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        halt = 1'b0;
	logic        pa = 1'b0;
	logic        pb = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [15:0] pdata, dout;
	logic [7:0]  sadl, s_sl;
	logic [3:0]  ula, s_ua;
	logic [1:0]  doe, s_oe;
	logic [2:0]  kind;
	logic [7:0]  mem [16];
	logic        hrdy, hresp, so, rd_n, wr_n, ds_n, rnw, ack, avail;
	logic        s_so, s_rnw, s_ack, s_av, act_q = 1'b0;
	int          num_errors = 0, tests_run = 0, cyc = 0;
	int          seed = 32'h81DA4D2F, wcnt = 0, w_last = 0, npulse = 0;
	int          wf [2];
	wire         act = !(rd_n && wr_n && ds_n);
	initial forever #2.5 clk_i = ~clk_i;
	ext_access_ctrl #(.CFG_W(7)) DUT (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.halt_i(halt), .upper_local_addr_o(ula),
		.sys_addr_data_lines_o(sadl), .sys_addr_data_lines_oe_o(so),
		.data_i(pdata), .data_o(dout), .data_oe_o(doe), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .data_strobe_n_o(ds_n), .rnw_o(rnw),
		.test_pin_a_i(pa), .test_pin_b_i(pb), .bus_ack_o(ack),
		.bus_avail_o(avail));
	slow_periph_model #(.DLY(40)) u_periph (
		.clk_i(clk_i), .addr_i(ula), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.ds_n_i(ds_n), .rnw_i(rnw), .wdata_i(dout), .oe_i(doe),
		.rdata_o(pdata));
	// ==========
	// strobe monitor: pulse count, width, pins in the second cycle
	always @(posedge clk_i) begin
		act_q <= act;
		if (act) wcnt = act_q ? wcnt + 1 : 1;
		else if (act_q) w_last = wcnt;
		if (act && !act_q) npulse++;
		if (act && wcnt == 2) begin
			kind = {!ds_n, !wr_n, !rd_n};
			{s_rnw, s_ua, s_sl, s_so, s_oe} = {rnw, ula, sadl, so, doe};
			{s_ack, s_av} = {ack, avail};
		end
	end
	// hang guard, well above the three thousand cycles expected
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		{hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
		haddr <= {20'h0, a};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	// one external access, polled to completion, then RDATA
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [15:0] d, output logic [31:0] r);
		int n = 0;
		npulse = 0;
		ahb(1'b1, 12'h008, {3'h0, w, a, d}, r);
		r = 32'h100;
		while (r[8] === 1'b1 && n < 100) begin
			ahb(1'b0, 12'h004, 32'h0, r);
			n++;
		end
		chk(r[8], 1'b0);
		ahb(1'b0, 12'h00C, 32'h0, r);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		logic [31:0] r;
		logic [15:0] d;
		logic [11:0] a;
		logic [6:0]  c;
		logic [1:0]  e;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		ahb(1'b0, 12'h000, 32'h0, r);
		chk(r, 32'h0);
		ahb(1'b1, 12'h000, 32'hFFFFFFFF, r);
		ahb(1'b0, 12'h000, 32'h0, r);
		chk(r, 32'h7F);
		ahb(1'b0, 12'h010, 32'h0, r);
		chk(r, 32'h0);
		$display("register test done");
		// every speed, role, bus and strobe mode, write then read
		for (int i = 0; i < 16; i++) begin
			c = {1'b1, i[1:0], i[3:0]};
			{pa, pb} <= 2'($random(seed));
			// the bench host always runs in its real mode
			ahb(1'b1, 12'h000, {25'h0, c}, r);
			a = 12'($random(seed));
			d = 16'($random(seed));
			e = (a[11:10] == 2'h0) ? 2'h1 : 2'h2;
			for (int w = 1; w >= 0; w--) begin
				acc(w[0], a, d, r);
				chk(npulse, c[0] ? 2 : 1);
				chk(kind, c[3] ? 3'h4 : (w ? 3'h2 : 3'h1));
				chk(s_rnw, c[3] ? !w[0] : 1'b1);
				chk(s_ua, a[11:8]);
				chk(s_so, c[1]);
				chk(c[1] ? s_sl : a[7:0], a[7:0]);
				chk(s_oe, !w ? 2'h0 : (c[2] ? 2'h3 : e));
				chk({s_ack, s_av}, {~c[4] & pa, ~c[5] & pb});
				if (c[0]) begin
					chk(w_last - wf[w], ext_access_pkg::EXTRA_CYC);
				end
				wf[w] = w_last;
				// whole byte replaced, as the peripheral does
				if (w && (c[2] || e == 2'h2)) mem[a[11:8]] = d[15:8];
				if (!w && c[0] && c[2]) begin
					chk(r[15:8], mem[a[11:8]]);
				end
				if (!w && !c[2] && e == 2'h1) begin
					chk(r[15:8], 8'h00);
				end
				if (!w && c[0] && !c[2] && e == 2'h2) begin
					chk(r, {16'h0, mem[a[11:8]], 8'h00});
				end
			end
		end
		$display("mode test done");
		// halt forcing, a refused write, restore only when masked
		for (int k = 0; k < 2; k++) begin
			c = k ? 7'h3B : 7'h7B;
			ahb(1'b1, 12'h000, {25'h0, c}, r);
			halt <= 1'b1;
			ahb(1'b1, 12'h000, 32'h0, r);
			ahb(1'b0, 12'h004, 32'h0, r);
			chk(r[7:0], {1'b1, c[6:4], 4'h6});
			halt <= 1'b0;
			ahb(1'b0, 12'h004, 32'h0, r);
			chk(r[6:0], c[6] ? c : {c[6:4], 4'h6});
		end
		$display("halt test done");
		test_done();
	end
endmodule
bind ext_access_ctrl ext_access_ctrl_asserts #(.CFG_W(CFG_W)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
	.data_strobe_n_o(data_strobe_n_o), .data_o(data_o),
	.upper_local_addr_o(upper_local_addr_o), .data_oe_o(data_oe_o),
	.test_pin_a_i(test_pin_a_i), .test_pin_b_i(test_pin_b_i),
	.bus_ack_o(bus_ack_o), .bus_avail_o(bus_avail_o));

// ===== test/slow_periph_model.sv
// Purpose: slow byte-wide peripheral on the upper data lane
// Assumes: a low strobe selects it
// Notes:   read data settles only after DLY strobe cycles
`timescale 1ns/1ps
module slow_periph_model #(
	parameter int DLY = 40
) (
	input  wire logic        clk_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        ds_n_i,
	input  wire logic        rnw_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  oe_i,
	output logic      [15:0] rdata_o
);
	logic [7:0] mem [16];
	logic [7:0] pat_q = 8'hA5;
	int         cnt_q = 0;
	wire        rd = !rd_n_i || (!ds_n_i && rnw_i);
	wire        wr = !wr_n_i || (!ds_n_i && !rnw_i);
	// churn the idle pattern so a stale bus never looks valid
	always @(posedge clk_i) begin
		pat_q <= pat_q + 8'h35;
		cnt_q <= rd ? cnt_q + 1 : 0;
		if (wr && oe_i[1]) begin
			mem[addr_i] <= wdata_i[15:8];
		end
	end
	// a short access sees junk, as the real part would give
	assign rdata_o = (rd && cnt_q >= DLY) ?
		{mem[addr_i], ~pat_q} : {pat_q, ~pat_q};
endmodule

// ===== verilog/ext_access_ctrl.sv
// Purpose: access mode register and external local bus controller
// Assumes: AHB-Lite single word transfers, one clock, sync reset
// Notes:   software starts each external access via the request register
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// How it works
// - seven-bit mode register, mask bit optional
// - bit0 picks 160 or 320 ns access
// - bit1 picks slave or pseudo-slave role
// - bit2 picks split bytes or 16-bit bus
// - bit3 picks read/write strobes or strobe+direction
// - bit4 clear makes test pin A acknowledge
// - bit5 clear makes test pin B bus-available
// - halt forces mode bits to fixed values
// - halt release restores mode only if masked
// - slow mode stretches control signals 160 ns
// - slow read samples data 160 ns later
// - slow mode performs external access twice
// - slave mode drives four upper address lines
// - pseudo-slave adds eight lower address lines
// - split read zeroes the unselected byte half
// - split write floats the unselected byte half
// - A10,A11 both low selects lower lane
module ext_access_ctrl #(
	parameter int CFG_W = 7
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// external halt
	input  wire logic        halt_i,
	// local bus
	output logic      [3:0]  upper_local_addr_o,
	output logic      [7:0]  sys_addr_data_lines_o,
	output logic             sys_addr_data_lines_oe_o,
	input  wire logic [15:0] data_i,
	output logic      [15:0] data_o,
	output logic      [1:0]  data_oe_o,
	output logic             rd_n_o,
	output logic             wr_n_o,
	output logic             data_strobe_n_o,
	output logic             rnw_o,
	// test pins
	input  wire logic        test_pin_a_i,
	input  wire logic        test_pin_b_i,
	output logic             bus_ack_o,
	output logic             bus_avail_o
);
	logic [CFG_W-1:0]              access_mode_reg_q;
	logic [CFG_W-1:0]              shadow_q;
	logic                          halt_q;
	logic [6:0]                    eff_mode;
	logic                          ap_valid_q;
	logic                          ap_write_q;
	logic [11:0]                   ap_addr_q;
	ext_access_pkg::ext_req_t      req_q;
	ext_access_pkg::phase_t        state_q;
	logic                          second_q;
	logic                          start;
	logic                          active;
	logic                          sample;
	logic [15:0]                   rdata_q;
	logic                          lane_hi;
	logic                          busy;
	logic                          req_wr;
	logic                          cfg_wr;
	ext_access_pkg::strobe_t       strb;

	// ======================================================================
	// bus slave address phase capture
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ap_valid_q <= 1'b0;
			ap_write_q <= 1'b0;
			ap_addr_q  <= '0;
		end else if (hready) begin
			ap_valid_q <= hsel && htrans[1];
			ap_write_q <= hwrite;
			ap_addr_q  <= haddr[11:0];
		end
	end

	// zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign req_wr    = ap_valid_q && ap_write_q &&
		ap_addr_q == ext_access_pkg::REQ_OFFSET && !busy;
	// mode write in its data phase; refused while halt holds the bus so
	// the shadow keeps the last value that software really chose
	assign cfg_wr    = ap_valid_q && ap_write_q &&
		ap_addr_q == ext_access_pkg::CFG_OFFSET && !halt_i;

	// ======================================================================
	// access mode register and shadow; halt overrides the live copy
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			access_mode_reg_q <= CFG_W'(ext_access_pkg::CFG_RESET);
			shadow_q          <= CFG_W'(ext_access_pkg::CFG_RESET);
			halt_q            <= 1'b0;
		end else begin
			halt_q <= halt_i;
			if (cfg_wr) begin
				access_mode_reg_q <= hwdata[CFG_W-1:0];
				shadow_q          <= hwdata[CFG_W-1:0];
			end else if (halt_i) begin
				access_mode_reg_q[3:0] <=
					ext_access_pkg::HALT_FORCE;
			end else if (halt_q) begin
				// release: restore only when the mask bit is set
				if (CFG_W > ext_access_pkg::BIT_MASK &&
				    shadow_q[CFG_W-1])
					access_mode_reg_q <= shadow_q;
			end
		end
	end

	// effective mode; the halt value is visible in the same cycle
	always_comb begin
		eff_mode = 7'(access_mode_reg_q);
		if (halt_i)
			eff_mode[3:0] = ext_access_pkg::HALT_FORCE;
	end

	// ======================================================================
	// request capture and repeat sequencing
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			req_q    <= '0;
			state_q  <= ext_access_pkg::ST_IDLE;
			second_q <= 1'b0;
		end else begin
			case (state_q)
			ext_access_pkg::ST_IDLE: begin
				if (req_wr) begin
					req_q.write <= hwdata[28];
					req_q.addr  <= hwdata[27:16];
					req_q.wdata <= hwdata[15:0];
					second_q    <= 1'b0;
					state_q     <= ext_access_pkg::ST_ACTIVE;
				end
			end
			ext_access_pkg::ST_ACTIVE: begin
				if (sample)
					state_q <= ext_access_pkg::ST_DONE;
			end
			ext_access_pkg::ST_DONE: begin
				// slow mode repeats the external access once
				if (eff_mode[ext_access_pkg::BIT_SLOW] && !second_q) begin
					second_q <= 1'b1;
					state_q  <= ext_access_pkg::ST_ACTIVE;
				end else begin
					state_q <= ext_access_pkg::ST_IDLE;
				end
			end
			default: state_q <= ext_access_pkg::ST_IDLE;
			endcase
		end
	end

	assign busy  = (state_q != ext_access_pkg::ST_IDLE);
	assign start = (state_q == ext_access_pkg::ST_ACTIVE) && !active;

	ext_access_cycle u_cycle (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.start_i  (start),
		.slow_i   (eff_mode[ext_access_pkg::BIT_SLOW]),
		.active_o (active),
		.sample_o (sample)
	);

	// ======================================================================
	// lane select: both A10 and A11 low picks the lower byte
	assign lane_hi = |req_q.addr[11:10];

	// read capture; split mode zeroes the unused half. both passes are
	// stored, software keeps the second
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else if (sample && !req_q.write) begin
			if (eff_mode[ext_access_pkg::BIT_JOINED])
				rdata_q <= data_i;
			else if (lane_hi)
				rdata_q <= {data_i[15:8], 8'h00};
			else
				rdata_q <= {8'h00, data_i[7:0]};
		end
	end

	// ======================================================================
	// address outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			upper_local_addr_o       <= '0;
			sys_addr_data_lines_o    <= '0;
			sys_addr_data_lines_oe_o <= 1'b0;
		end else begin
			upper_local_addr_o <= req_q.addr[11:8];
			sys_addr_data_lines_o <= req_q.addr[7:0];
			sys_addr_data_lines_oe_o <= active &&
				eff_mode[ext_access_pkg::BIT_PSEUDO];
		end
	end

	// ======================================================================
	// strobes and write data
	always_comb begin
		strb.rd_n = 1'b1;
		strb.wr_n = 1'b1;
		strb.ds_n = 1'b1;
		strb.rnw  = 1'b1;
		if (active) begin
			if (eff_mode[ext_access_pkg::BIT_STROBE]) begin
				strb.ds_n = 1'b0;
				strb.rnw  = !req_q.write;
			end else begin
				strb.rd_n = req_q.write;
				strb.wr_n = !req_q.write;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_n_o          <= 1'b1;
			wr_n_o          <= 1'b1;
			data_strobe_n_o <= 1'b1;
			rnw_o           <= 1'b1;
			data_o          <= '0;
			data_oe_o       <= 2'b00;
		end else begin
			rd_n_o          <= strb.rd_n;
			wr_n_o          <= strb.wr_n;
			data_strobe_n_o <= strb.ds_n;
			rnw_o           <= strb.rnw;
			data_o          <= req_q.wdata;
			if (!(active && req_q.write))
				data_oe_o <= 2'b00;
			else if (eff_mode[ext_access_pkg::BIT_JOINED])
				data_oe_o <= 2'b11;
			else
				data_oe_o <= {lane_hi, !lane_hi};
		end
	end

	// ======================================================================
	// test pin roles
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bus_ack_o   <= 1'b0;
			bus_avail_o <= 1'b0;
		end else begin
			bus_ack_o <= !eff_mode[ext_access_pkg::BIT_PIN_A] &&
				test_pin_a_i;
			bus_avail_o <= !eff_mode[ext_access_pkg::BIT_PIN_B] &&
				test_pin_b_i;
		end
	end

	// ======================================================================
	// read mux: data is registered in the address phase, so a write that
	// is still in its data phase is forwarded. without this a read right
	// behind a mode write shows the old mode, and a status poll right
	// behind a request write sees idle and hands back stale read data
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:0])
			ext_access_pkg::CFG_OFFSET:
				hrdata <= cfg_wr ? 32'(hwdata[CFG_W-1:0]) :
					32'(access_mode_reg_q);
			ext_access_pkg::STATUS_OFFSET:
				hrdata <= {21'h0, test_pin_b_i, test_pin_a_i,
					busy || req_wr, halt_i, eff_mode};
			ext_access_pkg::RDATA_OFFSET:
				hrdata <= {16'h0000, rdata_q};
			default:
				hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ===== verilog/ext_access_cycle.sv
// Purpose: times one external access and its strobes
// Assumes: start is a one-cycle pulse while idle
// Notes:   slow mode keeps signals asserted for the extra interval
`timescale 1ns/1ps
module ext_access_cycle (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	input  wire logic slow_i,
	output logic      active_o,
	output logic      sample_o
);
	localparam logic [ext_access_pkg::CNT_W-1:0] FAST_LEN =
		ext_access_pkg::CNT_W'(ext_access_pkg::FAST_CYC);
	localparam logic [ext_access_pkg::CNT_W-1:0] SLOW_LEN =
		ext_access_pkg::CNT_W'(ext_access_pkg::FAST_CYC +
		ext_access_pkg::EXTRA_CYC);

	logic [ext_access_pkg::CNT_W-1:0] cnt_q;
	logic [ext_access_pkg::CNT_W-1:0] len_q;

	// ======================================================================
	// cycle counter: length latched at start so a mode write mid-access
	// cannot stretch or cut the cycle in flight
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			len_q <= FAST_LEN;
		end else if (start_i && cnt_q == '0) begin
			cnt_q <= 8'h01;
			len_q <= slow_i ? SLOW_LEN : FAST_LEN;
		end else if (cnt_q != '0) begin
			cnt_q <= (cnt_q == len_q) ? '0 : cnt_q + 8'h01;
		end
	end

	assign active_o = (cnt_q != '0);
	// read data taken in the last cycle, later by the extra interval
	assign sample_o = (cnt_q != '0) && (cnt_q == len_q);
endmodule

// ===== verilog/ext_access_pkg.sv
// Purpose: shared constants and types for the external access controller
// Assumes: 200 MHz core clock, AHB-Lite register port, 32-bit data
// Notes:   all offsets, field positions and counts live here
package ext_access_pkg;

	// ======================================================================
	// register map (byte addresses)
	localparam logic [11:0] CFG_OFFSET     = 12'h000; // access mode register
	localparam logic [11:0] STATUS_OFFSET  = 12'h004; // effective mode, pins
	localparam logic [11:0] REQ_OFFSET     = 12'h008; // start an access
	localparam logic [11:0] RDATA_OFFSET   = 12'h00C; // last read data

	// ======================================================================
	// access mode field positions
	localparam int BIT_SLOW     = 0;
	localparam int BIT_PSEUDO   = 1;
	localparam int BIT_JOINED   = 2;
	localparam int BIT_STROBE   = 3;
	localparam int BIT_PIN_A    = 4;
	localparam int BIT_PIN_B    = 5;
	localparam int BIT_MASK     = 6;
	localparam logic [6:0] CFG_RESET = 7'h00;

	// halt forces bit0=0 bit1=1 bit2=1 bit3=0; only low four bits forced
	localparam logic [3:0] HALT_FORCE = 4'h6;

	// ======================================================================
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int FAST_NS       = 160;
	localparam int EXTRA_NS      = 160;
	localparam int FAST_CYC      = FAST_NS / CLK_PERIOD_NS;
	localparam int EXTRA_CYC     = EXTRA_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;

	// ======================================================================
	// types
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_DONE
	} phase_t;

	typedef struct packed {
		logic        write;
		logic [11:0] addr;
		logic [15:0] wdata;
	} ext_req_t;

	typedef struct packed {
		logic        rd_n;
		logic        wr_n;
		logic        ds_n;
		logic        rnw;
	} strobe_t;

endpackage
